// ==== dv/epa_checker.sv ====
// Purpose: port-level assertions for the eprom programmer controller
// Assumes: single clock domain, nrst async active low
// Notes:   pulse lengths measured by helper counters
`timescale 1ns/1ns
module epa_checker #(
    parameter int AW         = 14,
    parameter int PULSE_CYCP = 50000,
    parameter int CONV_CYCP  = 2500000
) (
    input wire logic          clk,              // clock
    input wire logic          nrst,             // async reset
    input wire logic          cmd_valid,        // command request
    input wire logic          cmd_ready,        // command accepted
    input wire logic          id_ok,            // id matched
    input wire logic [AW-1:0] addr,             // address pins
    input wire logic          hv_id_en,         // 12 V on id pin
    input wire logic          chip_select_n,    // chip enable
    input wire logic          output_drive_n,   // output enable
    input wire logic          program_strobe_n, // program pulse
    input wire logic          vpp_en,           // vpp raised
    input wire logic          dq_oe             // data drive enable
);
    logic [31:0] len_r;
    logic [4:0]  np_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // np_r counts pulses per command, overprogram included
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            len_r <= 32'h0;
            np_r  <= 5'h0;
        end else begin
            len_r <= program_strobe_n ? 32'h0 : len_r + 32'h1;
            if (cmd_valid && cmd_ready) np_r <= 5'h0;
            else if ($fell(program_strobe_n)) np_r <= np_r + 5'h1;
        end
    end
    a_id_addr_low: assert property (hv_id_en |-> addr[AW-1:1] == '0)
        else $error("address high bits set in id mode");
    a_id_no_vpp: assert property (hv_id_en |-> !vpp_en)
        else $error("vpp raised in id mode");
    a_strobe_qual: assert property (!program_strobe_n |->
        vpp_en && dq_oe && output_drive_n && !chip_select_n)
        else $error("program strobe without vpp, data or ce");
    a_no_contention: assert property (!output_drive_n |-> !dq_oe)
        else $error("data driven while outputs enabled");
    a_float_gap: assert property ($rose(output_drive_n) |-> !dq_oe [*7])
        else $error("data driven inside output float delay");
    a_oe_wait: assert property ($fell(output_drive_n) |-> !output_drive_n [*8])
        else $error("output enable released before data valid");
    a_pulse_len: assert property ($rose(program_strobe_n) |->
        (int'(len_r) == PULSE_CYCP || int'(len_r) == CONV_CYCP
        || int'(len_r) == 4 * (int'(np_r) - 1) * PULSE_CYCP))
        else $error("program pulse of wrong length");
    a_pulse_count: assert property (program_strobe_n |-> np_r <= 5'h10)
        else $error("too many pulses on one byte");
    a_refuse_prog: assert property (!id_ok |-> program_strobe_n)
        else $error("program pulse without id match");
endmodule

// ==== dv/epa_eprom_model.sv ====
// Purpose: behavioural bytewide eprom seen from its pins
// Assumes: lengths counted in controller clocks
// Notes:   need sets pulses before a cell takes; released bus toggles
`timescale 1ns/1ns
module epa_eprom_model #(
    parameter int         AW    = 14,
    parameter logic [6:0] MFR7  = 7'h15,  // arbitrary value
    parameter logic [6:0] PROD7 = 7'h23   // arbitrary value
) (
    input wire logic          clk,    // observation clock
    input wire logic [AW-1:0] addr,   // address pins
    input wire logic          hv,     // 12 V on id pin
    input wire logic          ce_n,   // chip enable
    input wire logic          oe_n,   // output enable
    input wire logic          pgm_n,  // program strobe
    input wire logic          vpp,    // programming supply
    input wire logic [7:0]    din,    // data from programmer
    input wire logic [4:0]    need,   // pulses before a byte takes
    output logic [7:0]        dout    // data to programmer
);
    logic [7:0]    mem [2**AW];
    logic [7:0]    val;
    logic          prog;
    logic          prog_q   = 1'b0;
    logic [AW-1:0] last_a   = '1;
    int            pulses   = 0;
    int            run      = 0;
    int            last_len = 0;
    // id row kept apart from mem, so erase never reaches it
    localparam logic [7:0] MFR  = {~^MFR7, MFR7};
    localparam logic [7:0] PROD = {~^PROD7, PROD7};
    initial begin
        dout = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    assign val = hv ? (addr[0] ? PROD : MFR) : mem[addr];
    always @(posedge clk) begin
        prog = !pgm_n && vpp && !ce_n;
        if (prog && !prog_q) begin
            pulses = (addr == last_a) ? pulses + 1 : 1;
            last_a = addr;
            run    = 0;
        end
        if (prog) run++;
        if (!prog && prog_q) begin
            last_len = run;
            // cells only go from one to zero
            if (pulses >= int'(need)) mem[last_a] = mem[last_a] & din;
        end
        prog_q = prog;
        dout <= (!ce_n && !oe_n && pgm_n) ? val : ~dout;
    end
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the eprom programmer controller
// Assumes: 50 MHz clock, short pulse parameters
// Notes:   device model checked through hierarchical peeks
`timescale 1ns/1ns
module tb;
    import epa_pkg::*;
    localparam int         PC = 20;
    localparam int         CC = 40;
    localparam logic [6:0] M7 = 7'h15;  // arbitrary value
    localparam logic [6:0] P7 = 7'h23;  // arbitrary value
    logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_conv = 1'b0;
    epa_op_e cmd_op = EPA_OP_ID;
    logic [13:0] cmd_addr = '0, addr;
    logic [7:0]  cmd_data = '0, exp_mfr = '0, exp_prod = '0, rsp_data, dq_o, dq_i, dev_q;
    logic [4:0]  need = 5'h1;
    logic [3:0]  rsp_tries;
    logic cmd_ready, rsp_valid, rsp_fail, id_ok, hv_id_en, chip_select_n;
    logic output_drive_n, program_strobe_n, vpp_en, vcc_hi, dq_oe;
    int mismatches = 0, checks_done = 0;
    always #10 clk = ~clk;
    assign dq_i = dq_oe ? dq_o : dev_q;
    epa_ctrl #(.AW(14), .PULSE_CYCP(PC), .CONV_CYCP(CC)) u_dut (.clk(clk), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_conv(cmd_conv),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .exp_mfr(exp_mfr), .exp_prod(exp_prod),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
        .rsp_tries(rsp_tries), .id_ok(id_ok), .addr(addr), .hv_id_en(hv_id_en),
        .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
        .program_strobe_n(program_strobe_n), .vpp_en(vpp_en), .vcc_hi(vcc_hi),
        .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
    epa_eprom_model #(.AW(14), .MFR7(M7), .PROD7(P7)) u_mem (.clk(clk), .addr(addr),
        .hv(hv_id_en), .ce_n(chip_select_n), .oe_n(output_drive_n),
        .pgm_n(program_strobe_n), .vpp(vpp_en), .din(dq_o), .need(need), .dout(dev_q));
    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until taken; waits bounded for the completion pulse
    task automatic run_cmd(input epa_op_e op, input logic conv, input logic [13:0] a,
                           input logic [7:0] d);
        int n;
        n = 0;
        cmd_op <= op; cmd_conv <= conv; cmd_addr <= a; cmd_data <= d; cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 20000);
        check("rsp_valid", rsp_valid, 1'b1);
    endtask
    task automatic t_id_refuse();
        exp_mfr <= {~^M7, M7}; exp_prod <= {^P7, P7};
        run_cmd(EPA_OP_ID, 1'b0, 14'h0, 8'h00);
        check("id fail", rsp_fail, 1'b1);
        check("id_ok", id_ok, 1'b0);
        run_cmd(EPA_OP_PROG, 1'b0, 14'h5, 8'h00);
        check("refused", rsp_fail, 1'b1);
        check("mem5", u_mem.mem[5], 8'hff);
    endtask
    task automatic t_id_match();
        exp_prod <= {~^P7, P7};
        run_cmd(EPA_OP_ID, 1'b0, 14'h0, 8'h00);
        check("id fail", rsp_fail, 1'b0);
        check("id byte1", rsp_data, {~^P7, P7});
        check("id_ok", id_ok, 1'b1);
    endtask
    task automatic t_adaptive();
        need <= 5'h3;
        run_cmd(EPA_OP_PROG, 1'b0, 14'h1, 8'ha5);
        check("fail", rsp_fail, 1'b0);
        check("tries", rsp_tries, 4'h3);
        check("pulses", u_mem.pulses, 4);
        check("overprogram", u_mem.last_len, 4 * 3 * PC);
        check("mem1", u_mem.mem[1], 8'ha5);
    endtask
    task automatic t_giveup();
        need <= 5'h10;
        run_cmd(EPA_OP_PROG, 1'b0, 14'h2, 8'h00);
        check("fail", rsp_fail, 1'b1);
        check("tries", rsp_tries, 4'hf);
        check("pulses", u_mem.pulses, 15);
    endtask
    task automatic t_conv();
        need <= 5'h1;
        run_cmd(EPA_OP_PROG, 1'b1, 14'h3, 8'h3c);
        check("fail", rsp_fail, 1'b0);
        check("pulses", u_mem.pulses, 1);
        check("conv len", u_mem.last_len, CC);
    endtask
    task automatic t_final_read();
        logic [7:0] exp [4];
        exp = '{8'ha5, 8'hff, 8'h3c, 8'hff};
        for (int i = 0; i < 4; i++) begin
            run_cmd(EPA_OP_READ, 1'b0, 14'(i + 1), 8'h00);
            check("read", rsp_data, exp[i]);
            check("supplies", {vpp_en, vcc_hi}, 2'b00);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_id_refuse();
        t_id_match();
        t_adaptive();
        t_giveup();
        t_conv();
        t_final_read();
        finish_test();
    end
    // whole run is a few thousand cycles
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
endmodule
bind epa_ctrl epa_checker #(.AW(AW), .PULSE_CYCP(PULSE_CYCP), .CONV_CYCP(CONV_CYCP)) u_chk (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .id_ok(id_ok),
    .addr(addr), .hv_id_en(hv_id_en), .chip_select_n(chip_select_n),
    .output_drive_n(output_drive_n), .program_strobe_n(program_strobe_n),
    .vpp_en(vpp_en), .dq_oe(dq_oe));

// ==== hw/epa_ctrl.sv ====
// Purpose: programmer driving an eprom through its pins
// Assumes: external switches turn vpp/12 V levels on from the *_en outputs, vcc to 6 V from vcc_hi
// Notes:   one command at a time; timing via epa_timer
// Function
// [R1] id mode: 12 V on id address pin, ce and oe low, other addresses low.
// [R2] device keeps id bytes in mask rom unaffected by erase.
// [R3] device offers two id bytes selected by the lowest address bit.
// [R4] id byte low seven bits are code, top bit odd parity.
// [R5] program only when id bytes match the expected codes.
// [R6] adaptive pulse-and-verify or one 50 ms conventional pulse.
// [R7] adaptive pulses on program strobe are each 1 ms.
// [R8] read back and compare after every 1 ms pulse.
// [R9] after verify pass, overprogram pulse of four times pulses used.
// [R10] at most fifteen 1 ms pulses per byte.
// [R11] overprogram length taken from the per-byte iteration counter.
// [R12] final verify reads all bytes with both supplies at 5 V.
// [R13] wait oe-to-data before sampling, float delay before driving again; a program command drives data as soon as it is taken.
// [R14] erased cells read one; programming only clears bits.
// [R15] write by strobe low with vpp raised and data driven.
// [R16] give up after fifteenth failed pulse and report failure.
`timescale 1ns/1ns
module epa_ctrl #(
    parameter int AW         = 14,               // address width
    parameter int PULSE_CYCP = epa_pkg::PULSE_CYC, // 1 ms in cycles
    parameter int CONV_CYCP  = epa_pkg::CONV_CYC   // 50 ms in cycles
) (
    input  wire logic          clk,        // clock
    input  wire logic          nrst,       // async reset, active low
    input  wire logic          cmd_valid,  // command request
    output logic               cmd_ready,  // idle, command accepted
    input  wire epa_pkg::epa_op_e cmd_op,  // id, program or read
    input  wire logic          cmd_conv,   // use conventional 50 ms pulse
    input  wire logic [AW-1:0] cmd_addr,   // byte address
    input  wire logic [7:0]    cmd_data,   // byte to program
    input  wire logic [7:0]    exp_mfr,    // expected byte 0
    input  wire logic [7:0]    exp_prod,   // expected byte 1
    output logic               rsp_valid,  // one-cycle completion pulse
    output logic [7:0]         rsp_data,   // read or id byte
    output logic               rsp_fail,   // verify failed / id mismatch
    output logic [3:0]         rsp_tries,  // pulses used on last byte
    output logic               id_ok,      // id matched, programming allowed
    output logic [AW-1:0]      addr,       // address pins
    output logic               hv_id_en,   // 12 V on high_voltage_id_address
    output logic               chip_select_n,  // chip enable
    output logic               output_drive_n, // output enable
    output logic               program_strobe_n, // program pulse
    output logic               vpp_en,     // programming_supply raised
    output logic               vcc_hi,     // vcc at 6 V for adaptive program
    output logic [7:0]         dq_o,       // data out
    output logic               dq_oe,      // data drive enable
    input  wire logic [7:0]    dq_i        // data pins in
);
    import epa_pkg::*;
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01, S_SETUP = 8'h02, S_PULSE = 8'h04, S_FLOAT = 8'h08,
        S_OE    = 8'h10, S_CHECK = 8'h20, S_OVER  = 8'h40, S_DONE  = 8'h80
    } epa_st_e;

    epa_st_e      st_r, st_nxt;
    epa_op_e      op_r;
    logic         conv_r, idb_r, ok_r, fail_r, idok_r, hv_r, vpp_r, vcc_r;
    logic         gap_r;          // float wait pending before data is driven again
    logic         oe_r, ce_r, pgm_r, dqoe_r, rv_r;
    logic [AW-1:0] addr_r;
    logic [7:0]   data_r, rd_r;
    logic [3:0]   tries_r;
    logic [7:0]   s1_r, s2_r;
    epa_tmr_if    tif();

    epa_timer u_tmr (.clk(clk), .nrst(nrst), .t(tif.tmr));

    // pin inputs are asynchronous to clk
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 8'h0;
            s2_r <= 8'h0;
        end else begin
            s1_r <= dq_i;
            s2_r <= s1_r;
        end
    end

    wire        go      = cmd_valid && (st_r == S_IDLE);
    wire        done    = tif.done;
    wire        is_prog = (op_r == EPA_OP_PROG);
    wire        is_id   = (op_r == EPA_OP_ID);
    wire        par_ok  = ^s2_r;                          // R4
    wire        match   = (s2_r == data_r);               // R8
    wire [7:0]  exp_b   = idb_r ? exp_prod : exp_mfr;
    wire        id_good = par_ok && (s2_r == exp_b);      // R5
    wire        give_up = (tries_r == 4'(MAX_TRIES));     // R10
    wire [31:0] over_cyc = 32'(OVER_MULT) * 32'(tries_r) * 32'(PULSE_CYCP); // R9 R11

    assign cmd_ready        = (st_r == S_IDLE);
    assign addr             = addr_r;
    assign hv_id_en         = hv_r;
    assign chip_select_n    = ce_r;
    assign output_drive_n   = oe_r;
    assign program_strobe_n = pgm_r;
    assign vpp_en           = vpp_r;
    assign vcc_hi           = vcc_r;
    assign dq_o             = data_r;
    assign dq_oe            = dqoe_r;
    assign rsp_valid        = rv_r;
    assign rsp_data         = rd_r;
    assign rsp_fail         = fail_r;
    assign rsp_tries        = tries_r;
    assign id_ok            = idok_r;

    always_comb begin
        st_nxt    = st_r;
        tif.load  = 1'b0;
        tif.count = 32'(SETUP_CYC);
        case (st_r)
            S_IDLE:  if (go) begin
                if (cmd_op == EPA_OP_PROG && !idok_r) begin
                    st_nxt    = S_DONE;                     // R5
                end else begin
                    st_nxt    = S_SETUP;
                    tif.load  = 1'b1;
                end
            end
            S_SETUP: if (done) begin
                if (gap_r) begin
                    tif.load  = 1'b1;                       // R13
                end else if (is_prog && ok_r) begin
                    st_nxt    = S_OVER;
                    tif.load  = 1'b1;
                    tif.count = over_cyc;                   // R9 R11
                end else if (is_prog) begin
                    st_nxt    = S_PULSE;
                    tif.load  = 1'b1;
                    tif.count = conv_r ? 32'(CONV_CYCP) : 32'(PULSE_CYCP); // R6 R7
                end else begin
                    st_nxt    = S_OE;
                    tif.load  = 1'b1;
                    tif.count = 32'(OE_CYC);                // R13
                end
            end
            S_PULSE: if (done) begin
                st_nxt    = S_FLOAT;
                tif.load  = 1'b1;
            end
            S_FLOAT: if (done) begin
                st_nxt    = S_OE;
                tif.load  = 1'b1;
                tif.count = 32'(OE_CYC);                    // R13
            end
            S_OE:    if (done) st_nxt = S_CHECK;
            S_CHECK: begin
                tif.load  = 1'b1;
                tif.count = 32'(FLOAT_CYC);                 // R13
                if (is_prog && !conv_r && (match || !give_up)) begin
                    st_nxt    = S_SETUP;                    // R8 R10
                end else if (is_id && !idb_r && id_good) begin
                    st_nxt    = S_OE;                       // R3
                    tif.count = 32'(OE_CYC);
                end else begin
                    st_nxt    = S_DONE;
                end
            end
            S_OVER:  if (done) st_nxt = S_DONE;
            S_DONE:  st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) st_r <= S_IDLE;
        else       st_r <= st_nxt;
    end

    // pin drive and bookkeeping
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_r <= EPA_OP_READ;  conv_r <= 1'b0;  idb_r <= 1'b0;  fail_r <= 1'b0;
            idok_r <= 1'b0;  hv_r <= 1'b0;  vpp_r <= 1'b0;  vcc_r <= 1'b0;
            oe_r <= 1'b1;  ce_r <= 1'b1;  pgm_r <= 1'b1;  dqoe_r <= 1'b0;
            rv_r <= 1'b0;  addr_r <= '0;  data_r <= ERASED;  rd_r <= 8'h0;
            tries_r <= 4'h0;  ok_r <= 1'b0;  gap_r <= 1'b0;
        end else begin
            rv_r <= 1'b0;
            case (st_r)
                S_IDLE: if (go) begin
                    op_r    <= cmd_op;
                    conv_r  <= cmd_conv;
                    data_r  <= cmd_data;
                    tries_r <= 4'h0;
                    idb_r   <= 1'b0;
                    fail_r  <= 1'b0;
                    ok_r    <= 1'b0;
                    gap_r   <= 1'b0;
                    ce_r    <= 1'b0;
                    if (cmd_op == EPA_OP_ID) begin
                        addr_r <= '0;                       // R1
                        hv_r   <= 1'b1;                     // R1
                    end else begin
                        addr_r <= cmd_addr;
                    end
                    if (cmd_op == EPA_OP_PROG) begin
                        if (!idok_r) begin                  // R5
                            ce_r   <= 1'b1;
                            fail_r <= 1'b1;
                        end else begin
                            vpp_r  <= 1'b1;                 // R15
                            vcc_r  <= !cmd_conv;
                            dqoe_r <= 1'b1;
                        end
                    end
                end
                S_SETUP: if (done && gap_r) begin
                    gap_r  <= 1'b0;
                    dqoe_r <= 1'b1;                         // R13
                end else if (done && is_prog) begin
                    pgm_r  <= 1'b0;                         // R15
                end
                S_PULSE: if (done) begin
                    pgm_r   <= 1'b1;
                    dqoe_r  <= 1'b0;
                    tries_r <= tries_r + 4'h1;              // R10
                end
                S_FLOAT: if (done) oe_r <= 1'b0;
                default: ;
            endcase
            if (st_r == S_SETUP && done && !is_prog) oe_r <= 1'b0;
            if (st_r == S_CHECK) begin
                oe_r <= 1'b1;
                rd_r <= s2_r;
                if (is_id) ok_r <= id_good;                 // R5
                if (is_id && !idb_r && id_good) begin
                    idb_r     <= 1'b1;
                    addr_r[0] <= 1'b1;                      // R3
                    oe_r      <= 1'b0;
                end
                if (is_prog) ok_r <= match;                 // R8
                // data stays off until the float delay has run out
                if (is_prog && !conv_r && (match || !give_up)) gap_r <= 1'b1; // R13
            end
            if (st_r == S_OVER && done) pgm_r <= 1'b1;
            if (st_r == S_DONE) begin
                rv_r   <= 1'b1;
                pgm_r  <= 1'b1;
                ce_r   <= 1'b1;
                oe_r   <= 1'b1;
                dqoe_r <= 1'b0;
                hv_r   <= 1'b0;
                vpp_r  <= 1'b0;                             // R12
                vcc_r  <= 1'b0;
                if (is_id) begin
                    idok_r <= idb_r && ok_r;
                    fail_r <= !(idb_r && ok_r);
                end else if (is_prog && idok_r) begin
                    fail_r <= !ok_r;                        // R16
                end
            end
        end
    end
endmodule

// ==== hw/epa_pkg.sv ====
// Purpose: constants for the eprom programmer controller
// Assumes: 50 MHz clock, 20 ns period
// Notes:   times kept in their own unit, cycle counts derived
package epa_pkg;
    localparam int CLK_NS          = 20;
    localparam int PULSE_US        = 1000;              // adaptive program pulse
    localparam int PULSE_CYC       = PULSE_US * 1000 / CLK_NS;
    localparam int CONV_US         = 50000;             // conventional pulse
    localparam int CONV_CYC        = CONV_US * 1000 / CLK_NS;
    localparam int SETUP_US        = 2;                 // address/data/oe/ce/vpp setup
    localparam int SETUP_CYC       = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int OE_NS           = 150;               // data valid from oe
    localparam int OE_CYC          = (OE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_NS        = 130;               // output float delay
    localparam int FLOAT_CYC       = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAX_TRIES       = 15;
    localparam int OVER_MULT       = 4;
    localparam logic [7:0] ERASED  = 8'hff;
    typedef enum logic [1:0] {
        EPA_OP_ID   = 2'h0,
        EPA_OP_PROG = 2'h1,
        EPA_OP_READ = 2'h2
    } epa_op_e;
endpackage

// ==== hw/epa_timer.sv ====
// Purpose: down counter timing pulses and setup waits
// Assumes: load not raised while busy except to restart
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ns
module epa_timer (
    input  wire logic clk,    // clock
    input  wire logic nrst,   // async reset, active low
    epa_tmr_if.tmr    t       // controller side
);
    logic [31:0] cnt_r;
    logic        run_r;
    wire         last = run_r && (cnt_r <= 32'h1);
    // done straight from the count, so a load of n spans exactly n cycles
    assign t.done = last;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= 32'h0;
            run_r  <= 1'b0;
        end else begin
            if (t.load) begin
                cnt_r <= t.count;
                run_r <= 1'b1;
            end else if (last) begin
                run_r <= 1'b0;
            end else if (run_r) begin
                cnt_r <= cnt_r - 32'h1;
            end
        end
    end
endmodule

// ==== hw/epa_tmr_if.sv ====
// Purpose: link between controller and its pulse timer
// Assumes: single clock
// Notes:   load starts a count, done pulses once at the end
`timescale 1ns/1ns
interface epa_tmr_if;
    logic        load;
    logic [31:0] count;
    logic        done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface
